// file: inc/acu_pkg.sv
// Package of the 8-bit counter unit: register map, field positions,
// mode and clock-select encodings and the carrier structs.
// Assumes a single clock domain; the crystal pin is synchronised in the counter unit.
package acu_pkg;

	localparam int ACU_DW    = 8;
	localparam int ACU_AW    = 4;
	localparam int ACU_PRE_W = 10;

	// Register offsets
	localparam logic [ACU_AW-1:0] ACU_OFS_CTRL_A = 4'h0;
	localparam logic [ACU_AW-1:0] ACU_OFS_CTRL_B = 4'h1;
	localparam logic [ACU_AW-1:0] ACU_OFS_COUNT  = 4'h2;
	localparam logic [ACU_AW-1:0] ACU_OFS_CMP_A  = 4'h3;
	localparam logic [ACU_AW-1:0] ACU_OFS_CMP_B  = 4'h4;
	localparam logic [ACU_AW-1:0] ACU_OFS_MASK   = 4'h5;
	localparam logic [ACU_AW-1:0] ACU_OFS_FLAG   = 4'h6;
	localparam logic [ACU_AW-1:0] ACU_OFS_ASYNC  = 4'h7;
	localparam logic [ACU_AW-1:0] ACU_OFS_POWER  = 4'h8;

	// Field positions
	localparam int ACU_CRA_WM_LSB   = 0;
	localparam int ACU_CRA_COMB_LSB = 4;
	localparam int ACU_CRA_COMA_LSB = 6;
	localparam int ACU_CRB_CS_LSB   = 0;
	localparam int ACU_CRB_WM2_BIT  = 3;
	localparam int ACU_FLG_OVF      = 0;
	localparam int ACU_FLG_CMPA     = 1;
	localparam int ACU_FLG_CMPB     = 2;
	localparam int ACU_FLG_W        = 3;
	localparam int ACU_ASYNC_BIT    = 5;
	localparam int ACU_PWR_BIT      = 0;

	// Count landmarks
	localparam logic [ACU_DW-1:0] ACU_BOTTOM = 8'h00;
	localparam logic [ACU_DW-1:0] ACU_MAX    = 8'hFF;
	localparam logic [ACU_DW-1:0] ACU_ONE    = 8'h01;

	typedef enum logic [2:0] {
		ACU_WM_NORMAL    = 3'b000,
		ACU_WM_PC_MAX    = 3'b001,
		ACU_WM_CTC       = 3'b010,
		ACU_WM_FAST_MAX  = 3'b011,
		ACU_WM_RSV4      = 3'b100,
		ACU_WM_PC_CMPA   = 3'b101,
		ACU_WM_RSV6      = 3'b110,
		ACU_WM_FAST_CMPA = 3'b111
	} acu_mode_e;

	typedef enum logic [2:0] {
		ACU_CS_STOP    = 3'b000,
		ACU_CS_DIV1    = 3'b001,
		ACU_CS_DIV8    = 3'b010,
		ACU_CS_DIV32   = 3'b011,
		ACU_CS_DIV64   = 3'b100,
		ACU_CS_DIV128  = 3'b101,
		ACU_CS_DIV256  = 3'b110,
		ACU_CS_DIV1024 = 3'b111
	} acu_cs_e;

	typedef enum logic [1:0] {
		ACU_COM_OFF    = 2'b00,
		ACU_COM_TOGGLE = 2'b01,
		ACU_COM_CLEAR  = 2'b10,
		ACU_COM_SET    = 2'b11
	} acu_com_e;

	// Prescaler tap masks: a tick when the masked bits are all ones
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M1    = 10'h000;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M8    = 10'h007;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M32   = 10'h01F;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M64   = 10'h03F;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M128  = 10'h07F;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M256  = 10'h0FF;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_M1024 = 10'h3FF;
	localparam logic [ACU_PRE_W-1:0] ACU_PRE_ONE   = 10'h001;

	typedef struct packed {
		logic [ACU_AW-1:0] addr;
		logic [ACU_DW-1:0] wdata;
		logic              wr;
		logic              rd;
	} acu_bus_s;

	typedef struct packed {
		logic tick;
		logic fast;
		logic dual;
		logic down;
		logic at_top;
		logic buffered;
	} acu_wave_s;

endpackage

// file: design/acu_compare_ch.sv
// One compare channel: double-buffered compare value, match detect and
// the waveform output flip-flop.
// Assumes tick and mode information arrive from the counter on the same clock.
`timescale 1ns/1ps
`default_nettype none
module acu_compare_ch
	import acu_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              wr_val,
	input  wire logic [ACU_DW-1:0] wval,
	input  wire acu_wave_s         wave,
	input  wire acu_com_e          com,
	input  wire logic [ACU_DW-1:0] cnt,
	output logic      [ACU_DW-1:0] buf_val,
	output logic      [ACU_DW-1:0] act_val,
	output logic                   match,
	output logic                   pin
);

	typedef struct packed {
		logic [ACU_DW-1:0] buf_val;
		logic [ACU_DW-1:0] act_val;
		logic              pin;
	} acu_ch_state_s;

	acu_ch_state_s s_reg;
	acu_ch_state_s s_next;

	assign buf_val = s_reg.buf_val;
	assign act_val = s_reg.act_val;
	assign pin     = s_reg.pin;
	assign match   = (cnt == s_reg.act_val);

	always_comb begin
		s_next = s_reg;
		if (wr_val) begin
			s_next.buf_val = wval;
		end
		// Unbuffered modes see writes at once; PWM modes only at TOP
		if (!wave.buffered) begin
			s_next.act_val = s_next.buf_val;
		end else if (wave.tick && wave.at_top) begin
			s_next.act_val = s_next.buf_val;
		end
		if (wave.tick) begin
			if (wave.dual) begin
				if (match) begin
					case (com)
						ACU_COM_TOGGLE: s_next.pin = ~s_reg.pin;
						ACU_COM_CLEAR:  s_next.pin = wave.down;
						ACU_COM_SET:    s_next.pin = ~wave.down;
						default:        s_next.pin = s_reg.pin;
					endcase
				end
			end else begin
				if (match) begin
					case (com)
						ACU_COM_TOGGLE: s_next.pin = ~s_reg.pin;
						ACU_COM_CLEAR:  s_next.pin = 1'b0;
						ACU_COM_SET:    s_next.pin = 1'b1;
						default:        s_next.pin = s_reg.pin;
					endcase
				end
				// Wrap wins over match so a value at TOP gives a steady level
				if (wave.fast && wave.at_top) begin
					if (com == ACU_COM_CLEAR) begin
						s_next.pin = 1'b1;
					end else if (com == ACU_COM_SET) begin
						s_next.pin = 1'b0;
					end
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule
`default_nettype wire

// file: design/acu_counter_unit.sv
// Counter unit of the 8-bit timer: clock selection and prescaler, the
// bi-directional counter, flags, masks and the register port.
// Assumes a synchronous register port on clock; the crystal pin is
// asynchronous and is synchronised here before use.
`timescale 1ns/1ps
`default_nettype none

module acu_counter_unit
	import acu_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire acu_bus_s          bus_req,
	output logic      [ACU_DW-1:0] rd_data,
	input  wire logic              crystal_pin_1,
	output logic                   compare_out_a,
	output logic                   compare_out_b,
	output logic [ACU_FLG_W-1:0]   int_req
);

	typedef struct packed {
		logic                 xtal_s1;
		logic                 xtal_s2;
		logic                 xtal_s3;
		logic [ACU_PRE_W-1:0] presc;
		logic [ACU_DW-1:0]    cnt;
		logic                 down;
		logic [ACU_DW-1:0]    ctrl_a;
		logic [ACU_DW-1:0]    ctrl_b;
		logic [ACU_FLG_W-1:0] mask;
		logic [ACU_FLG_W-1:0] flags;
		logic                 async_sel;
		logic                 pwr;
		logic [ACU_DW-1:0]    rdata;
		logic [ACU_FLG_W-1:0] irq;
	} acu_state_s;

	acu_state_s s_reg;
	acu_state_s s_next;

	acu_mode_e            mode;
	acu_cs_e              cs;
	acu_wave_s            wave;
	logic                 src_tick;
	logic                 running;
	logic [ACU_PRE_W-1:0] tap_mask;
	logic [ACU_DW-1:0]    top_val;
	logic                 ovf_set;
	logic [ACU_DW-1:0]    cnt_step;
	logic                 down_step;
	logic [ACU_DW-1:0]    buf_a;
	logic [ACU_DW-1:0]    buf_b;
	logic [ACU_DW-1:0]    act_a;
	logic [ACU_DW-1:0]    act_b;
	logic                 match_a;
	logic                 match_b;
	logic                 wr_cmp_a;
	logic                 wr_cmp_b;

	assign rd_data = s_reg.rdata;
	assign int_req = s_reg.irq;

	assign wr_cmp_a = bus_req.wr && (bus_req.addr == ACU_OFS_CMP_A);
	assign wr_cmp_b = bus_req.wr && (bus_req.addr == ACU_OFS_CMP_B);

	// Mode and clock selection
	always_comb begin
		mode = acu_mode_e'({s_reg.ctrl_b[ACU_CRB_WM2_BIT], s_reg.ctrl_a[ACU_CRA_WM_LSB +: 2]});
		cs   = acu_cs_e'(s_reg.ctrl_b[ACU_CRB_CS_LSB +: 3]);
		// Crystal edges only after two flops; the third keeps the edge detect off the first
		src_tick = s_reg.async_sel ? (s_reg.xtal_s2 & ~s_reg.xtal_s3) : 1'b1;
		running  = !s_reg.pwr && (cs != ACU_CS_STOP);
		case (cs)
			ACU_CS_DIV8:    tap_mask = ACU_PRE_M8;
			ACU_CS_DIV32:   tap_mask = ACU_PRE_M32;
			ACU_CS_DIV64:   tap_mask = ACU_PRE_M64;
			ACU_CS_DIV128:  tap_mask = ACU_PRE_M128;
			ACU_CS_DIV256:  tap_mask = ACU_PRE_M256;
			ACU_CS_DIV1024: tap_mask = ACU_PRE_M1024;
			default:        tap_mask = ACU_PRE_M1;
		endcase
		if ((mode == ACU_WM_CTC) || (mode == ACU_WM_PC_CMPA) || (mode == ACU_WM_FAST_CMPA)) begin
			top_val = act_a;
		end else begin
			top_val = ACU_MAX;
		end
		wave.tick     = running && src_tick && ((s_reg.presc & tap_mask) == tap_mask);
		wave.fast     = (mode == ACU_WM_FAST_MAX) || (mode == ACU_WM_FAST_CMPA);
		wave.dual     = (mode == ACU_WM_PC_MAX) || (mode == ACU_WM_PC_CMPA);
		wave.down     = s_reg.down;
		wave.at_top   = (s_reg.cnt == top_val);
		wave.buffered = wave.fast || wave.dual;
	end

	// Count sequence for one tick
	always_comb begin
		cnt_step  = s_reg.cnt + ACU_ONE;
		down_step = 1'b0;
		ovf_set   = 1'b0;
		case (mode)
			ACU_WM_PC_MAX, ACU_WM_PC_CMPA: begin
				down_step = s_reg.down;
				if (!s_reg.down) begin
					if (wave.at_top) begin
						down_step = 1'b1;
						cnt_step  = s_reg.cnt - ACU_ONE;
					end
				end else begin
					if (s_reg.cnt == ACU_BOTTOM) begin
						down_step = 1'b0;
						ovf_set   = 1'b1;
					end else begin
						cnt_step = s_reg.cnt - ACU_ONE;
					end
				end
			end
			ACU_WM_CTC: begin
				if (wave.at_top) begin
					cnt_step = ACU_BOTTOM;
				end
				ovf_set = (s_reg.cnt == ACU_MAX);
			end
			ACU_WM_FAST_MAX, ACU_WM_FAST_CMPA: begin
				if (wave.at_top) begin
					cnt_step = ACU_BOTTOM;
				end
				ovf_set = wave.at_top;
			end
			default: begin
				// Reserved codes run as normal mode rather than freeze
				ovf_set = (s_reg.cnt == ACU_MAX);
			end
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.xtal_s1 = crystal_pin_1;
		s_next.xtal_s2 = s_reg.xtal_s1;
		s_next.xtal_s3 = s_reg.xtal_s2;
		// Prescaler free runs on its source while the module is powered
		if (!s_reg.pwr && src_tick) begin
			s_next.presc = s_reg.presc + ACU_PRE_ONE;
		end
		if (wave.tick) begin
			s_next.cnt  = cnt_step;
			s_next.down = down_step;
		end
		if (!wave.dual) begin
			s_next.down = 1'b0;
		end
		// Write one to clear; a set in the same cycle still wins
		if (bus_req.wr && (bus_req.addr == ACU_OFS_FLAG)) begin
			s_next.flags = s_reg.flags & ~bus_req.wdata[ACU_FLG_W-1:0];
		end
		if (wave.tick) begin
			s_next.flags[ACU_FLG_OVF]  = s_next.flags[ACU_FLG_OVF] | ovf_set;
			s_next.flags[ACU_FLG_CMPA] = s_next.flags[ACU_FLG_CMPA] | match_a;
			s_next.flags[ACU_FLG_CMPB] = s_next.flags[ACU_FLG_CMPB] | match_b;
		end
		if (bus_req.wr) begin
			if (bus_req.addr == ACU_OFS_CTRL_A) begin
				s_next.ctrl_a = bus_req.wdata;
			end else if (bus_req.addr == ACU_OFS_CTRL_B) begin
				s_next.ctrl_b = bus_req.wdata;
			end else if (bus_req.addr == ACU_OFS_COUNT) begin
				s_next.cnt = bus_req.wdata;
			end else if (bus_req.addr == ACU_OFS_MASK) begin
				s_next.mask = bus_req.wdata[ACU_FLG_W-1:0];
			end else if (bus_req.addr == ACU_OFS_ASYNC) begin
				s_next.async_sel = bus_req.wdata[ACU_ASYNC_BIT];
			end else if (bus_req.addr == ACU_OFS_POWER) begin
				s_next.pwr = bus_req.wdata[ACU_PWR_BIT];
			end
		end
		s_next.irq   = s_next.flags & s_next.mask;
		s_next.rdata = '0;
		if (bus_req.rd) begin
			if (bus_req.addr == ACU_OFS_CTRL_A) begin
				s_next.rdata = s_reg.ctrl_a;
			end else if (bus_req.addr == ACU_OFS_CTRL_B) begin
				s_next.rdata = s_reg.ctrl_b;
			end else if (bus_req.addr == ACU_OFS_COUNT) begin
				s_next.rdata = s_reg.cnt;
			end else if (bus_req.addr == ACU_OFS_CMP_A) begin
				s_next.rdata = buf_a;
			end else if (bus_req.addr == ACU_OFS_CMP_B) begin
				s_next.rdata = buf_b;
			end else if (bus_req.addr == ACU_OFS_MASK) begin
				s_next.rdata[ACU_FLG_W-1:0] = s_reg.mask;
			end else if (bus_req.addr == ACU_OFS_FLAG) begin
				s_next.rdata[ACU_FLG_W-1:0] = s_reg.flags;
			end else if (bus_req.addr == ACU_OFS_ASYNC) begin
				s_next.rdata[ACU_ASYNC_BIT] = s_reg.async_sel;
			end else if (bus_req.addr == ACU_OFS_POWER) begin
				s_next.rdata[ACU_PWR_BIT] = s_reg.pwr;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	acu_compare_ch u_cmp_a (
		.clock   (clock),
		.rst_n   (rst_n),
		.wr_val  (wr_cmp_a),
		.wval    (bus_req.wdata),
		.wave    (wave),
		.com     (acu_com_e'(s_reg.ctrl_a[ACU_CRA_COMA_LSB +: 2])),
		.cnt     (s_reg.cnt),
		.buf_val (buf_a),
		.act_val (act_a),
		.match   (match_a),
		.pin     (compare_out_a)
	);

	acu_compare_ch u_cmp_b (
		.clock   (clock),
		.rst_n   (rst_n),
		.wr_val  (wr_cmp_b),
		.wval    (bus_req.wdata),
		.wave    (wave),
		.com     (acu_com_e'(s_reg.ctrl_a[ACU_CRA_COMB_LSB +: 2])),
		.cnt     (s_reg.cnt),
		.buf_val (buf_b),
		.act_val (act_b),
		.match   (match_b),
		.pin     (compare_out_b)
	);

endmodule
`default_nettype wire

// file: tb/acu_counter_monitor.sv
// Checker of the counter unit ports: read port, register echo, flags, reset.
// Assumes it is bound to acu_counter_unit and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module acu_counter_monitor
	import acu_pkg::*;
(
	input wire logic                 clock,
	input wire logic                 rst_n,
	input wire acu_bus_s             bus_req,
	input wire logic [ACU_DW-1:0]    rd_data,
	input wire logic                 crystal_pin_1,
	input wire logic                 compare_out_a,
	input wire logic                 compare_out_b,
	input wire logic [ACU_FLG_W-1:0] int_req
);
	// Shadows of the fields that gate ticks and interrupt requests
	logic [2:0]           cs_reg;
	logic                 pwr_reg;
	logic [ACU_FLG_W-1:0] mask_reg;
	logic                 halt;
	default clocking cb @(posedge clock);
	endclocking
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cs_reg   <= 3'h0;
			pwr_reg  <= 1'b0;
			mask_reg <= '0;
		end else if (bus_req.wr) begin
			cs_reg   <= (bus_req.addr == ACU_OFS_CTRL_B) ? bus_req.wdata[2:0] : cs_reg;
			pwr_reg  <= (bus_req.addr == ACU_OFS_POWER) ? bus_req.wdata[ACU_PWR_BIT] : pwr_reg;
			mask_reg <= (bus_req.addr == ACU_OFS_MASK) ? bus_req.wdata[ACU_FLG_W-1:0] : mask_reg;
		end
	end
	assign halt = (cs_reg == 3'h0) || pwr_reg;
	property p_rst;
		!rst_n |=> int_req == '0 && rd_data == 8'h00 && !compare_out_a && !compare_out_b;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_rd_idle;
		disable iff (!rst_n) !bus_req.rd |=> rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside a read");
	property p_unmap;
		disable iff (!rst_n) bus_req.rd && bus_req.addr > ACU_OFS_POWER |=> rd_data == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_rsv;
		disable iff (!rst_n) bus_req.rd && bus_req.addr == ACU_OFS_ASYNC |=> (rd_data & 8'hDF) == 8'h00;
	endproperty
	a_rsv: assert property (p_rsv) else $error("async register spare bits set");
	property p_cnt_wb;
		disable iff (!rst_n) bus_req.wr && bus_req.addr == ACU_OFS_COUNT ##2
			bus_req.rd && bus_req.addr == ACU_OFS_COUNT && halt && $past(halt) |=> rd_data == $past(bus_req.wdata, 3);
	endproperty
	a_cnt_wb: assert property (p_cnt_wb) else $error("count write not read back");
	property p_cmp_wb;
		disable iff (!rst_n) bus_req.wr && (bus_req.addr == ACU_OFS_CMP_A || bus_req.addr == ACU_OFS_CMP_B) ##2
			bus_req.rd && bus_req.addr == $past(bus_req.addr, 2) |=> rd_data == $past(bus_req.wdata, 3);
	endproperty
	a_cmp_wb: assert property (p_cmp_wb) else $error("compare write not read back");
	property p_mask;
		disable iff (!rst_n) (int_req & ~mask_reg) == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("masked request raised");
	property p_fclr;
		disable iff (!rst_n) bus_req.wr && bus_req.addr == ACU_OFS_FLAG && bus_req.wdata[2:0] == 3'h7 && halt
			|=> int_req == '0;
	endproperty
	a_fclr: assert property (p_fclr) else $error("flags not cleared by write");
	property p_stop;
		disable iff (!rst_n) halt && $past(halt) && !bus_req.wr |=> $stable(int_req);
	endproperty
	a_stop: assert property (p_stop) else $error("request moved while stopped");
	property p_pwr;
		disable iff (!rst_n) pwr_reg && $past(pwr_reg) && !bus_req.wr |=> $stable(int_req);
	endproperty
	a_pwr: assert property (p_pwr) else $error("request moved while powered down");
	c_read: cover property (bus_req.rd);
	c_irq: cover property (int_req != '0);
	c_pin: cover property ($rose(compare_out_a));
endmodule
bind acu_counter_unit acu_counter_monitor i_acu_counter_monitor (.clock(clock), .rst_n(rst_n),
	.bus_req(bus_req), .rd_data(rd_data), .crystal_pin_1(crystal_pin_1), .compare_out_a(compare_out_a),
	.compare_out_b(compare_out_b), .int_req(int_req));
`default_nettype wire

// file: tb/tb_acu_counter_unit.sv
// Self-checking bench of the counter unit: register table, then mode scenarios.
// Assumes a 40 MHz clock, a synchronous low reset and the package register map.
`timescale 1ns/1ps
`default_nettype none
module tb_acu_counter_unit
	import acu_pkg::*;
;
	typedef struct packed {
		logic [ACU_AW-1:0] a;
		logic [ACU_DW-1:0] d;
		logic [ACU_DW-1:0] e;
	} acu_row_s;
	logic                 clock = 1'b0;
	logic                 rst_n = 1'b0;
	acu_bus_s             bus_req = '0;
	logic [ACU_DW-1:0]    rd_data;
	logic                 crystal_pin_1 = 1'b0;
	logic                 compare_out_a;
	logic                 compare_out_b;
	logic [ACU_FLG_W-1:0] int_req;
	logic [ACU_DW-1:0]    q;
	int                   n_fail = 0;
	int                   checks_done = 0;
	// Value written beside the value read back; spare bits read as zero
	acu_row_s rows [10] = '{
		'{ACU_OFS_CTRL_A, 8'hF3, 8'hF3}, '{ACU_OFS_CTRL_B, 8'h08, 8'h08},
		'{ACU_OFS_COUNT, 8'h3C, 8'h3C}, '{ACU_OFS_CMP_A, 8'hA5, 8'hA5},
		'{ACU_OFS_CMP_B, 8'h5A, 8'h5A}, '{ACU_OFS_MASK, 8'hFF, 8'h07},
		'{ACU_OFS_FLAG, 8'hFF, 8'h00}, '{ACU_OFS_ASYNC, 8'hFF, 8'h20},
		'{ACU_OFS_POWER, 8'hFF, 8'h01}, '{4'hC, 8'hFF, 8'h00}};
	always #12.5 clock = ~clock;
	acu_counter_unit i_acu_counter_unit (
		.clock         (clock),
		.rst_n         (rst_n),
		.bus_req       (bus_req),
		.rd_data       (rd_data),
		.crystal_pin_1 (crystal_pin_1),
		.compare_out_a (compare_out_a),
		.compare_out_b (compare_out_b),
		.int_req       (int_req)
	);
	// One strobe cycle, then one idle cycle, so no signal is driven twice in a step
	task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
		@(posedge clock);
		bus_req <= '0;
		#1;
		q = rd_data;
		@(posedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [3:0] a);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cnt(input logic [7:0] e);
		rd(ACU_OFS_COUNT);
		chk("count", e, q);
	endtask
	// Exactly k ticks at divide-by-one: start write, k-2 idle cycles, stop write
	task automatic run(input int k, input logic [7:0] b);
		wr(ACU_OFS_CTRL_B, b | 8'h01);
		repeat (k - 2) @(posedge clock);
		wr(ACU_OFS_CTRL_B, b);
	endtask
	task automatic reset_dut();
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		reset_dut();
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk("register", rows[i].e, q);
		end
		$display("test registers done");
		reset_dut();
		chk("outputs", 8'h00, {3'h0, int_req, compare_out_a, compare_out_b});
		for (int i = 0; i < 9; i++) begin
			rd(4'(i));
			chk("reset value", 8'h00, q);
		end
		$display("test reset done");
		wr(ACU_OFS_MASK, 8'h07);
		wr(ACU_OFS_COUNT, 8'hFE);
		run(2, 8'h00);
		cnt(8'h00);
		rd(ACU_OFS_FLAG);
		chk("flags", 8'h01, q);
		chk("int_req", 8'h01, {5'h00, int_req});
		wr(ACU_OFS_FLAG, 8'h07);
		chk("int_req", 8'h00, {5'h00, int_req});
		$display("test normal done");
		wr(ACU_OFS_CMP_A, 8'h05);
		wr(ACU_OFS_CMP_B, 8'h03);
		wr(ACU_OFS_CTRL_A, 8'h52);
		wr(ACU_OFS_MASK, 8'h03);
		run(8, 8'h00);
		cnt(8'h02);
		rd(ACU_OFS_FLAG);
		chk("flags", 8'h06, q);
		chk("int_req", 8'h02, {5'h00, int_req});
		chk("pins", 8'h03, {6'h00, compare_out_a, compare_out_b});
		$display("test clear on match done");
		reset_dut();
		wr(ACU_OFS_CTRL_A, 8'h03);
		wr(ACU_OFS_COUNT, 8'hFE);
		run(3, 8'h00);
		cnt(8'h01);
		rd(ACU_OFS_FLAG);
		chk("flags", 8'h07, q);
		reset_dut();
		wr(ACU_OFS_CMP_A, 8'h03);
		wr(ACU_OFS_CTRL_A, 8'h03);
		wr(ACU_OFS_COUNT, 8'h02);
		run(3, 8'h08);
		cnt(8'h01);
		reset_dut();
		wr(ACU_OFS_CTRL_A, 8'hB3);
		wr(ACU_OFS_CMP_A, 8'h02);
		wr(ACU_OFS_CMP_B, 8'h02);
		rd(ACU_OFS_CMP_A);
		chk("buffered compare", 8'h02, q);
		wr(ACU_OFS_COUNT, 8'hFE);
		run(3, 8'h00);
		chk("pins at top", 8'h02, {6'h00, compare_out_a, compare_out_b});
		run(2, 8'h00);
		chk("pins at match", 8'h01, {6'h00, compare_out_a, compare_out_b});
		$display("test fast pwm done");
		reset_dut();
		wr(ACU_OFS_CTRL_A, 8'h01);
		wr(ACU_OFS_COUNT, 8'hFD);
		run(4, 8'h00);
		cnt(8'hFD);
		reset_dut();
		wr(ACU_OFS_CMP_A, 8'h04);
		wr(ACU_OFS_CTRL_A, 8'h01);
		wr(ACU_OFS_COUNT, 8'h02);
		run(5, 8'h08);
		cnt(8'h01);
		$display("test phase correct done");
		reset_dut();
		wr(ACU_OFS_POWER, 8'h01);
		wr(ACU_OFS_COUNT, 8'h10);
		run(6, 8'h00);
		cnt(8'h10);
		wr(ACU_OFS_POWER, 8'h00);
		repeat (10) @(posedge clock);
		cnt(8'h10);
		wr(ACU_OFS_CTRL_B, 8'h01);
		wr(ACU_OFS_COUNT, 8'h40);
		wr(ACU_OFS_CTRL_B, 8'h00);
		cnt(8'h42);
		$display("test halt and priority done");
		reset_dut();
		wr(ACU_OFS_ASYNC, 8'h20);
		wr(ACU_OFS_CTRL_B, 8'h01);
		repeat (4) begin
			crystal_pin_1 <= 1'b1;
			repeat (4) @(posedge clock);
			crystal_pin_1 <= 1'b0;
			repeat (4) @(posedge clock);
		end
		wr(ACU_OFS_CTRL_B, 8'h00);
		cnt(8'h04);
		$display("test crystal clock done");
		summarize();
	end
	initial begin
		repeat (5000) @(posedge clock);
		n_fail++;
		summarize();
	end
endmodule
`default_nettype wire
